// file: design/pfsel_pkg.sv
/*
  pfsel_pkg: register offsets, field positions, reset values and masks
  for the pin function select block of port pins p2.6, p2.7, p3.0, p3.1.
  Assumes a 16-bit register address space with byte-wide registers.
*/
package pfsel_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [15:0] P2_6_CFG_OFS = 16'ha076;
  localparam logic [15:0] P2_7_CFG_OFS = 16'ha077;
  localparam logic [15:0] P3_0_CFG_OFS = 16'ha078;
  localparam logic [15:0] P3_1_CFG_OFS = 16'ha079;

  // reset value shared by all four registers
  localparam logic [7:0] CFG_RESET = 8'h00;

  // field positions
  localparam int GENERAL_IO_BIT = 0;
  localparam int IRQ0_SRC_BIT = 1;
  localparam int IRQ1_SRC_BIT = 2;
  localparam int SPI_PIN_BIT = 3;
  localparam int CAPCOMP_BIT = 4;
  localparam int LED_SEG_BIT = 7;

  // implemented-bit masks per register
  localparam logic [7:0] P2_6_MASK = 8'h99;
  localparam logic [7:0] P2_7_MASK = 8'h99;
  localparam logic [7:0] P3_0_MASK = 8'h97;
  localparam logic [7:0] P3_1_MASK = 8'h97;

  // one-hot pin function after priority resolution
  typedef enum logic [4:0] {
    PFSEL_FN_NONE = 5'h01,
    PFSEL_FN_GPIO = 5'h02,
    PFSEL_FN_SPI = 5'h04,
    PFSEL_FN_CAPCOMP = 5'h08,
    PFSEL_FN_LED = 5'h10
  } pfsel_fn_t;
endpackage

// file: design/pfsel_top.sv
/*
  pfsel_top: four per-pin function configuration registers and the pin
  routing they steer (led segment, capture/compare, spi, timer 2 input,
  general io) plus pin sources for the two shared pin interrupts.
  Assumes a single-cycle register port on clk_i, synchronous inputs and
  that the peripherals sit outside and hand in/out plain signals.
  Function bits on one pin resolve with the highest bit winning, so
  software should set only one of them. Interrupt source bits act
  beside the pin function and only gate the raw pad level; edge or
  level detection sits in the interrupt controller outside.
*/
// Strobed register access is this design's own decision.
`timescale 1ns/1ns

// Behaviour
// R01: four 8-bit read/write pin configuration registers, all reset to zero.
// R02: bit 0 selects plain general io for the pin; cleared after reset.
// R03: p2.6 bit 7 drives that pin as led segment 20.
// R04: p2.6 bit 4 connects the pin to capture/compare channel 5.
// R05: p2.6 bit 3 uses the pin as spi slave-select input.
// R06: p2.7 bit 7 drives that pin as led segment 19.
// R07: p2.7 bit 4 routes the pin to timer 2 external input.
// R08: p2.7 bit 3 uses the pin as bidirectional spi clock.
// R09: p3.0 bit 7 drives that pin as led segment 18.
// R10: p3.0 bit 4 connects the pin to capture/compare channel 2.
// R11: p3.1 bit 7 drives that pin as led segment 17.
// R12: p3.1 bit 4 connects the pin to capture/compare channel 3.
// R13: p3 pins with bit 2 set feed shared pin interrupt 1.
// R14: p3 pins with bit 1 set feed shared pin interrupt 0.
// R15: one pin may feed both shared pin interrupts independently.
// R16: undefined bits read zero and ignore writes.
// R17: conflicting function bits resolve with highest-numbered bit winning.
module pfsel_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [pfsel_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [pfsel_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [pfsel_pkg::DATA_W-1:0] reg_rdata_o,
  // pad side, index 0..3 = p2.6, p2.7, p3.0, p3.1
  input wire logic [3:0] pad_in_i,
  output logic [3:0] pad_out_o,
  output logic [3:0] pad_oe_o,
  // general io port logic
  input wire logic [3:0] gpio_out_i,
  input wire logic [3:0] gpio_oe_i,
  output logic [3:0] gpio_in_o,
  // led segment drivers 20, 19, 18, 17
  input wire logic [3:0] led_seg_i,
  // capture/compare channels 5, 2, 3
  input wire logic capcomp_channel5_out_i,
  input wire logic capcomp_channel5_oe_i,
  output logic capcomp_channel5_in_o,
  input wire logic capcomp_channel2_out_i,
  input wire logic capcomp_channel2_oe_i,
  output logic capcomp_channel2_in_o,
  input wire logic capcomp_channel3_out_i,
  input wire logic capcomp_channel3_oe_i,
  output logic capcomp_channel3_in_o,
  // spi
  output logic spi_slave_select_n_o,
  input wire logic spi_clock_out_i,
  input wire logic spi_clock_oe_i,
  output logic spi_clock_in_o,
  // timer 2
  output logic timer2_external_input_o,
  // shared pin interrupt sources, index 0 = p3.0, 1 = p3.1
  output logic [1:0] shared_pin_irq0_src_o,
  output logic [1:0] shared_pin_irq1_src_o,
  // current one-hot function per pin
  output logic [19:0] pin_function_o
);
  import pfsel_pkg::*;

  logic [7:0] cfg_r [4];
  logic [7:0] rdata_nxt;
  pfsel_fn_t fn [4];
  logic [3:0] alt_out;
  logic [3:0] alt_oe;
  // named selects taken straight from the configuration bits
  logic led_segment_20_select;
  logic led_segment_19_select;
  logic led_segment_18_select;
  logic led_segment_17_select;
  logic capcomp_ch5_pin_select;
  logic capcomp_ch2_pin_select;
  logic capcomp_ch3_pin_select;
  logic spi_slave_select_pin_select;
  logic spi_clock_pin_select;
  logic timer2_ext_input_select;
  logic [3:0] general_io_select;
  logic [1:0] pin_irq0_source_select;
  logic [1:0] pin_irq1_source_select;

  // led segment selects, bit 7 of each register
  assign led_segment_20_select = cfg_r[0][LED_SEG_BIT]; // R03
  assign led_segment_19_select = cfg_r[1][LED_SEG_BIT]; // R06
  assign led_segment_18_select = cfg_r[2][LED_SEG_BIT]; // R09
  assign led_segment_17_select = cfg_r[3][LED_SEG_BIT]; // R11

  // bit 4 selects: capture/compare channels and the timer 2 input
  assign capcomp_ch5_pin_select = cfg_r[0][CAPCOMP_BIT]; // R04
  assign timer2_ext_input_select = cfg_r[1][CAPCOMP_BIT]; // R07
  assign capcomp_ch2_pin_select = cfg_r[2][CAPCOMP_BIT]; // R10
  assign capcomp_ch3_pin_select = cfg_r[3][CAPCOMP_BIT]; // R12

  // bit 3 selects exist only on the port 2 pins
  assign spi_slave_select_pin_select = cfg_r[0][SPI_PIN_BIT]; // R05
  assign spi_clock_pin_select = cfg_r[1][SPI_PIN_BIT]; // R08

  // general io enable, bit 0 of every register
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      general_io_select[i] = cfg_r[i][GENERAL_IO_BIT]; // R02
    end
  end

  // interrupt source enables live only on the port 3 pins
  always_comb begin
    pin_irq0_source_select[0] = cfg_r[2][IRQ0_SRC_BIT]; // R14
    pin_irq0_source_select[1] = cfg_r[3][IRQ0_SRC_BIT]; // R14
    pin_irq1_source_select[0] = cfg_r[2][IRQ1_SRC_BIT]; // R13
    pin_irq1_source_select[1] = cfg_r[3][IRQ1_SRC_BIT]; // R13
  end

  // register writes, undefined bits masked off
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 4; i++) begin
        cfg_r[i] <= CFG_RESET; // R01 R02
      end
    end else if (reg_wr_i) begin
      if (reg_addr_i == P2_6_CFG_OFS) begin
        cfg_r[0] <= reg_wdata_i & P2_6_MASK; // R01 R16
      end else if (reg_addr_i == P2_7_CFG_OFS) begin
        cfg_r[1] <= reg_wdata_i & P2_7_MASK; // R01 R16
      end else if (reg_addr_i == P3_0_CFG_OFS) begin
        cfg_r[2] <= reg_wdata_i & P3_0_MASK; // R01 R16
      end else if (reg_addr_i == P3_1_CFG_OFS) begin
        cfg_r[3] <= reg_wdata_i & P3_1_MASK; // R01 R16
      end
    end
  end

  // read decode, unmapped reads return zero
  always_comb begin
    if (reg_addr_i == P2_6_CFG_OFS) begin
      rdata_nxt = cfg_r[0];
    end else if (reg_addr_i == P2_7_CFG_OFS) begin
      rdata_nxt = cfg_r[1];
    end else if (reg_addr_i == P3_0_CFG_OFS) begin
      rdata_nxt = cfg_r[2];
    end else if (reg_addr_i == P3_1_CFG_OFS) begin
      rdata_nxt = cfg_r[3];
    end else begin
      rdata_nxt = 8'h00;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // priority resolve per pin: bit 7, then 4, then 3, then 0
  always_comb begin
    // p2.6: led 20, capture/compare 5, slave select, general io
    if (led_segment_20_select) begin
      fn[0] = PFSEL_FN_LED; // R17
    end else if (capcomp_ch5_pin_select) begin
      fn[0] = PFSEL_FN_CAPCOMP; // R17
    end else if (spi_slave_select_pin_select) begin
      fn[0] = PFSEL_FN_SPI; // R17
    end else if (general_io_select[0]) begin
      fn[0] = PFSEL_FN_GPIO; // R02
    end else begin
      fn[0] = PFSEL_FN_NONE;
    end
    // p2.7: led 19, timer 2 input, spi clock, general io
    if (led_segment_19_select) begin
      fn[1] = PFSEL_FN_LED; // R17
    end else if (timer2_ext_input_select) begin
      fn[1] = PFSEL_FN_CAPCOMP; // R17
    end else if (spi_clock_pin_select) begin
      fn[1] = PFSEL_FN_SPI; // R17
    end else if (general_io_select[1]) begin
      fn[1] = PFSEL_FN_GPIO; // R02
    end else begin
      fn[1] = PFSEL_FN_NONE;
    end
    // p3.0: led 18, capture/compare 2, general io
    if (led_segment_18_select) begin
      fn[2] = PFSEL_FN_LED; // R17
    end else if (capcomp_ch2_pin_select) begin
      fn[2] = PFSEL_FN_CAPCOMP; // R17
    end else if (general_io_select[2]) begin
      fn[2] = PFSEL_FN_GPIO; // R02
    end else begin
      fn[2] = PFSEL_FN_NONE;
    end
    // p3.1: led 17, capture/compare 3, general io
    if (led_segment_17_select) begin
      fn[3] = PFSEL_FN_LED; // R17
    end else if (capcomp_ch3_pin_select) begin
      fn[3] = PFSEL_FN_CAPCOMP; // R17
    end else if (general_io_select[3]) begin
      fn[3] = PFSEL_FN_GPIO; // R02
    end else begin
      fn[3] = PFSEL_FN_NONE;
    end
  end

  assign pin_function_o = {fn[3], fn[2], fn[1], fn[0]};

  // alternate function drive per pin
  always_comb begin
    alt_out = 4'h0;
    alt_oe = 4'h0;
    // p2.6: capture/compare 5 or spi slave select (input only)
    if (fn[0] == PFSEL_FN_CAPCOMP) begin
      alt_out[0] = capcomp_channel5_out_i; // R04
      alt_oe[0] = capcomp_channel5_oe_i; // R04
    end
    // p2.7: timer 2 input (input only) or spi clock
    if (fn[1] == PFSEL_FN_SPI) begin
      alt_out[1] = spi_clock_out_i; // R08
      alt_oe[1] = spi_clock_oe_i; // R08
    end
    // p3.0: capture/compare 2
    if (fn[2] == PFSEL_FN_CAPCOMP) begin
      alt_out[2] = capcomp_channel2_out_i; // R10
      alt_oe[2] = capcomp_channel2_oe_i; // R10
    end
    // p3.1: capture/compare 3
    if (fn[3] == PFSEL_FN_CAPCOMP) begin
      alt_out[3] = capcomp_channel3_out_i; // R12
      alt_oe[3] = capcomp_channel3_oe_i; // R12
    end
  end

  // final pad mux, led segments always drive
  always_comb begin
    // p2.6
    if (fn[0] == PFSEL_FN_LED) begin
      pad_out_o[0] = led_seg_i[0]; // R03
      pad_oe_o[0] = 1'b1; // R03
    end else if (fn[0] == PFSEL_FN_GPIO) begin
      pad_out_o[0] = gpio_out_i[0]; // R02
      pad_oe_o[0] = gpio_oe_i[0]; // R02
    end else begin
      pad_out_o[0] = alt_out[0];
      pad_oe_o[0] = alt_oe[0];
    end
    // p2.7
    if (fn[1] == PFSEL_FN_LED) begin
      pad_out_o[1] = led_seg_i[1]; // R06
      pad_oe_o[1] = 1'b1; // R06
    end else if (fn[1] == PFSEL_FN_GPIO) begin
      pad_out_o[1] = gpio_out_i[1]; // R02
      pad_oe_o[1] = gpio_oe_i[1]; // R02
    end else begin
      pad_out_o[1] = alt_out[1];
      pad_oe_o[1] = alt_oe[1];
    end
    // p3.0
    if (fn[2] == PFSEL_FN_LED) begin
      pad_out_o[2] = led_seg_i[2]; // R09
      pad_oe_o[2] = 1'b1; // R09
    end else if (fn[2] == PFSEL_FN_GPIO) begin
      pad_out_o[2] = gpio_out_i[2]; // R02
      pad_oe_o[2] = gpio_oe_i[2]; // R02
    end else begin
      pad_out_o[2] = alt_out[2];
      pad_oe_o[2] = alt_oe[2];
    end
    // p3.1
    if (fn[3] == PFSEL_FN_LED) begin
      pad_out_o[3] = led_seg_i[3]; // R11
      pad_oe_o[3] = 1'b1; // R11
    end else if (fn[3] == PFSEL_FN_GPIO) begin
      pad_out_o[3] = gpio_out_i[3]; // R02
      pad_oe_o[3] = gpio_oe_i[3]; // R02
    end else begin
      pad_out_o[3] = alt_out[3];
      pad_oe_o[3] = alt_oe[3];
    end
  end

  // input routing to peripherals, idle values when not selected
  always_comb begin
    gpio_in_o = 4'h0;
    capcomp_channel5_in_o = 1'b0;
    capcomp_channel2_in_o = 1'b0;
    capcomp_channel3_in_o = 1'b0;
    spi_slave_select_n_o = 1'b1; // idle high when not routed
    spi_clock_in_o = 1'b0;
    timer2_external_input_o = 1'b0;
    // p2.6 feeds general io, capture/compare 5 or slave select
    if (fn[0] == PFSEL_FN_GPIO) begin
      gpio_in_o[0] = pad_in_i[0]; // R02
    end else if (fn[0] == PFSEL_FN_CAPCOMP) begin
      capcomp_channel5_in_o = pad_in_i[0]; // R04
    end else if (fn[0] == PFSEL_FN_SPI) begin
      spi_slave_select_n_o = pad_in_i[0]; // R05
    end
    // p2.7 feeds general io, timer 2 or the spi clock
    if (fn[1] == PFSEL_FN_GPIO) begin
      gpio_in_o[1] = pad_in_i[1]; // R02
    end else if (fn[1] == PFSEL_FN_CAPCOMP) begin
      timer2_external_input_o = pad_in_i[1]; // R07
    end else if (fn[1] == PFSEL_FN_SPI) begin
      spi_clock_in_o = pad_in_i[1]; // R08
    end
    // p3.0 feeds general io or capture/compare 2
    if (fn[2] == PFSEL_FN_GPIO) begin
      gpio_in_o[2] = pad_in_i[2]; // R02
    end else if (fn[2] == PFSEL_FN_CAPCOMP) begin
      capcomp_channel2_in_o = pad_in_i[2]; // R10
    end
    // p3.1 feeds general io or capture/compare 3
    if (fn[3] == PFSEL_FN_GPIO) begin
      gpio_in_o[3] = pad_in_i[3]; // R02
    end else if (fn[3] == PFSEL_FN_CAPCOMP) begin
      capcomp_channel3_in_o = pad_in_i[3]; // R12
    end
  end

  // pin interrupt sources, independent of pin function and of each other
  always_comb begin
    // p3.0 may feed either or both shared interrupts
    shared_pin_irq0_src_o[0] =
      pin_irq0_source_select[0] & pad_in_i[2]; // R14 R15
    shared_pin_irq1_src_o[0] =
      pin_irq1_source_select[0] & pad_in_i[2]; // R13 R15
    // p3.1 likewise
    shared_pin_irq0_src_o[1] =
      pin_irq0_source_select[1] & pad_in_i[3]; // R14 R15
    shared_pin_irq1_src_o[1] =
      pin_irq1_source_select[1] & pad_in_i[3]; // R13 R15
  end
endmodule

// file: test/pfsel_top_assertions.sv
/* pfsel_top_assertions: port checks for pfsel_top.
   assumes it is bound onto pfsel_top from the testbench top file. */
`timescale 1ns/1ns
module pfsel_chk import pfsel_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [3:0] pad_in_i,
  input wire logic [3:0] pad_out_o,
  input wire logic [3:0] pad_oe_o,
  input wire logic [3:0] led_seg_i,
  input wire logic spi_slave_select_n_o,
  input wire logic timer2_external_input_o,
  input wire logic [1:0] shared_pin_irq0_src_o,
  input wire logic [1:0] shared_pin_irq1_src_o,
  input wire logic [19:0] pin_function_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // read data only in the cycle after a read
  a_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not idle");
  // no pad driven on the first edge after reset
  a_fn_reset: assert property ($past(sys_rst_i) |-> pad_oe_o == 4'h0)
    else $error("pad driven after reset");
  // led segment routing on both ends of the pad range
  a_led_p26: assert property (pin_function_o[4:0] == PFSEL_FN_LED
    |-> pad_oe_o[0] && pad_out_o[0] == led_seg_i[0]) else $error("seg 20");
  a_led_p31: assert property (pin_function_o[19:15] == PFSEL_FN_LED
    |-> pad_oe_o[3] && pad_out_o[3] == led_seg_i[3]) else $error("seg 17");
  // slave select follows the pad only when chosen
  a_ssn_route: assert property (spi_slave_select_n_o ==
    (pin_function_o[4:0] == PFSEL_FN_SPI ? pad_in_i[0] : 1'h1))
    else $error("slave select routing");
  a_t2_route: assert property (timer2_external_input_o ==
    (pin_function_o[9:5] == PFSEL_FN_CAPCOMP ? pad_in_i[1] : 1'h0))
    else $error("timer 2 input routing");
  // interrupt sources never rise without a high pad
  a_irq0_gate: assert property (
    (shared_pin_irq0_src_o & ~pad_in_i[3:2]) == 2'h0)
    else $error("irq0 source not gated");
  a_irq1_gate: assert property (
    (shared_pin_irq1_src_o & ~pad_in_i[3:2]) == 2'h0)
    else $error("irq1 source not gated");
endmodule

// file: test/pfsel_top_tb_top.sv
/* pfsel_top_tb_top: directed register and pin routing tests.
   assumes pfsel_pkg and the checker module pfsel_chk. */
`timescale 1ns/1ns
module pfsel_top_tb_top;
  import pfsel_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, wr = 0, rd = 0, so = 0, se = 0;
  logic [15:0] ad = 16'h0000;
  logic [7:0] wd = 8'h00, rdat;
  logic [3:0] pin = 4'h0, go = 4'h0, ge = 4'h0, led = 4'h0, pout, poe, gi;
  logic [2:0] co = 3'h0, ce = 3'h0, ci;
  logic ssn_n, si, t2;
  logic [1:0] q0, q1;
  logic [19:0] fn;
  int n_mismatch = 0, check_count = 0;
  always #50 clk_i = ~clk_i;
  pfsel_top u_pfsel_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .pad_in_i(pin), .pad_out_o(pout), .pad_oe_o(poe),
    .gpio_out_i(go), .gpio_oe_i(ge), .gpio_in_o(gi), .led_seg_i(led),
    .capcomp_channel5_out_i(co[0]), .capcomp_channel5_oe_i(ce[0]),
    .capcomp_channel5_in_o(ci[0]), .capcomp_channel2_out_i(co[1]),
    .capcomp_channel2_oe_i(ce[1]), .capcomp_channel2_in_o(ci[1]),
    .capcomp_channel3_out_i(co[2]), .capcomp_channel3_oe_i(ce[2]),
    .capcomp_channel3_in_o(ci[2]), .spi_slave_select_n_o(ssn_n),
    .spi_clock_out_i(so), .spi_clock_oe_i(se), .spi_clock_in_o(si),
    .timer2_external_input_o(t2), .shared_pin_irq0_src_o(q0),
    .shared_pin_irq1_src_o(q1), .pin_function_o(fn));
  // compare and count
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle write, outputs settle 10 ns after the taking edge
  task automatic wrt(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    ad <= a;
    wd <= d;
    wr <= 1'h1;
    @(posedge clk_i);
    wr <= 1'h0;
    #10;
  endtask
  // one-cycle read, data checked in the next cycle and then zero
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    ad <= a;
    rd <= 1'h1;
    @(posedge clk_i);
    rd <= 1'h0;
    #10 chk(rdat, e);
    @(posedge clk_i);
    #10 chk(rdat, 8'h00);
  endtask
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog at 10000 cycles, far beyond the 70 or so cycles of the tests
  initial begin
    #1000000;
    n_mismatch++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    for (int i = 0; i < 4; i++) rdc(16'ha076 + 16'(i), 8'h00);
    led <= 4'ha;
    pin <= 4'h4;
    for (int i = 0; i < 4; i++) wrt(16'ha076 + 16'(i), 8'hff);
    chk({poe, pout}, 8'hfa);
    chk({q1, q0}, 4'h5);
    for (int i = 0; i < 4; i++) begin
      rdc(16'ha076 + 16'(i), i < 2 ? 8'h99 : 8'h97);
    end
    wrt(16'ha07a, 8'hff);
    rdc(16'ha07a, 8'h00);
    wrt(16'ha078, 8'h04);
    wrt(16'ha079, 8'h02);
    pin <= 4'hc;
    #1 chk({q1, q0}, 4'h6);
    co <= 3'h3;
    ce <= 3'h6;
    pin <= 4'hb;
    for (int i = 0; i < 4; i++) wrt(16'ha076 + 16'(i), 8'h10);
    chk(fn, {4{PFSEL_FN_CAPCOMP}});
    chk({poe, pout[3:2], ci, t2}, 10'h31b);
    so <= 1'h1;
    se <= 1'h1;
    pin <= 4'h2;
    wrt(16'ha076, 8'h08);
    wrt(16'ha077, 8'h08);
    chk({poe[1], pout[1], si, ssn_n}, 4'he);
    go <= 4'h9;
    ge <= 4'hf;
    pin <= 4'h6;
    for (int i = 0; i < 4; i++) wrt(16'ha076 + 16'(i), 8'h01);
    chk({poe, pout, gi}, 12'hf96);
    end_of_test();
  end
endmodule
bind pfsel_top pfsel_chk u_pfsel_chk (.*);
